// *** hdl/cpw_pkg.sv ***
// Constants, register map and carrier types for the PWM timer block
package cpw_pkg;

  // ---------------------------------------------------------------
  // Bus and register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFF_COUNTER = 6'h00;
  localparam logic [5:0] OFF_LIMIT = 6'h04;
  localparam logic [5:0] OFF_TCTRL = 6'h08;
  localparam logic [5:0] OFF_C1_BUF = 6'h0c;
  localparam logic [5:0] OFF_C1_ACT = 6'h10;
  localparam logic [5:0] OFF_C1_CTRL = 6'h14;
  localparam logic [5:0] OFF_C2_BUF = 6'h18;
  localparam logic [5:0] OFF_C2_ACT = 6'h1c;
  localparam logic [5:0] OFF_C2_CTRL = 6'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Field positions and values
  // ---------------------------------------------------------------
  localparam int TC_PS_LSB = 0;
  localparam int TC_RUN_BIT = 2;
  localparam int TC_POST_LSB = 3;
  localparam int CC_MODE_LSB = 0;
  localparam int CC_DLO_LSB = 4;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [1:0] MODE_PWM_HI = 2'h3;
  localparam logic [7:0] C2_CTRL_MASK = 8'h3f;
  localparam logic [3:0] PS_MAX_1 = 4'h0;
  localparam logic [3:0] PS_MAX_4 = 4'h3;
  localparam logic [3:0] PS_MAX_16 = 4'hf;
  localparam logic [7:0] RST_LIMIT = 8'hff;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int TCY_NS = 40;
  localparam int TCY_CYCLES = (TCY_NS + CLK_NS - 1) / CLK_NS;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PS_DIV1 = 2'h0, PS_DIV4 = 2'h1, PS_DIV16 = 2'h2, PS_DIV16B = 2'h3} cpw_ps_type;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } cpw_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cpw_axi_rsp_type;

  typedef struct packed {
    cpw_axi_rsp_type rsp;
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_strb0;
    logic [7:0] counter;
    logic [7:0] limit;
    logic [6:0] tctrl;
    logic [3:0] presc;
    logic [1:0][7:0] dbuf;
    logic [1:0][7:0] dact;
    logic [1:0][1:0] dlat;
    logic [1:0][7:0] cctrl;
    logic [1:0] out;
    logic sd_meta;
    logic sd_s2;
    logic sd_s3;
    logic sd_q;
  } cpw_state_type;

  localparam cpw_state_type ST_RESET = '{limit: RST_LIMIT, default: '0};

endpackage

// *** hdl/cpw_top.sv ***
// Two-channel PWM generator on an 8-bit period timer with AXI4-Lite registers
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module cpw_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire cpw_pkg::cpw_axi_req_type axi_req,
  output cpw_pkg::cpw_axi_rsp_type axi_rsp,
  input wire logic shutdown_in,
  output logic [1:0] pwm_output_pin
);

  // ---------------------------------------------------------------
  // State and derived terms
  // ---------------------------------------------------------------
  cpw_pkg::cpw_state_type st_q;
  cpw_pkg::cpw_state_type st_d;

  cpw_pkg::cpw_ps_type ps_sel;
  logic [3:0] ps_max;
  logic timer_run;
  logic tick;
  logic roll;
  logic wr_go;
  logic wr_en;
  logic [1:0] pwm_on;
  logic [1:0] chan_off;
  logic [1:0] match;
  logic [1:0][9:0] duty_next;
  logic [7:0] cnt_nx;
  logic [3:0] presc_nx;

  assign ps_sel = cpw_pkg::cpw_ps_type'(st_q.tctrl[cpw_pkg::TC_PS_LSB +: 2]);
  assign timer_run = st_q.tctrl[cpw_pkg::TC_RUN_BIT];
  // Postscale bits are stored for software only; nothing here reads them
  assign ps_max = (ps_sel == cpw_pkg::PS_DIV1) ? cpw_pkg::PS_MAX_1 :
                  (ps_sel == cpw_pkg::PS_DIV4) ? cpw_pkg::PS_MAX_4 : cpw_pkg::PS_MAX_16;
  // At or past the limit, so a smaller prescale chosen mid-count never stalls the count
  assign tick = timer_run && (st_q.presc >= ps_max);
  assign roll = tick && (st_q.counter == st_q.limit);
  assign cnt_nx = roll ? 8'h00 : (tick ? st_q.counter + 8'h01 : st_q.counter);
  assign presc_nx = tick ? 4'h0 : (timer_run ? st_q.presc + 4'h1 : st_q.presc);
  assign wr_go = st_q.aw_full && st_q.w_full && !st_q.rsp.bvalid;
  assign wr_en = wr_go && st_q.w_strb0;

  // ---------------------------------------------------------------
  // Duty comparison per channel
  // ---------------------------------------------------------------
  // At divide-by-one there is no sub-cycle phase to compare against, so the
  // two low duty bits are ignored there and resolution drops to eight bits.
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    logic [1:0] sub;
    assign pwm_on[i] = (st_q.cctrl[i][3:2] == cpw_pkg::MODE_PWM_HI);
    assign chan_off[i] = (st_q.cctrl[i][cpw_pkg::CC_MODE_LSB +: 4] == cpw_pkg::MODE_OFF);
    assign duty_next[i] = {st_q.dbuf[i], st_q.cctrl[i][cpw_pkg::CC_DLO_LSB +: 2]};
    assign sub = (ps_sel == cpw_pkg::PS_DIV4) ? presc_nx[1:0] :
                 (ps_sel == cpw_pkg::PS_DIV1) ? st_q.dlat[i] : presc_nx[3:2];
    // A duty past the period end never equals the count, so the pin stays high
    // Compared with the count after this edge, so the registered pin falls as the count reaches the duty
    assign match[i] = ({st_q.dact[i], st_q.dlat[i]} == {cnt_nx, sub});
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;

    // Write address and data are taken independently, in either order
    if (st_q.rsp.awready && axi_req.awvalid) begin
      st_d.aw_full = 1'b1;
      st_d.aw_addr = axi_req.awaddr;
    end
    if (st_q.rsp.wready && axi_req.wvalid) begin
      st_d.w_full = 1'b1;
      st_d.w_data = axi_req.wdata[7:0];
      st_d.w_strb0 = axi_req.wstrb[0];
    end
    if (st_q.rsp.bvalid && axi_req.bready) begin
      st_d.rsp.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_d.aw_full = 1'b0;
      st_d.w_full = 1'b0;
      st_d.rsp.bvalid = 1'b1;
      case (st_q.aw_addr)
        cpw_pkg::OFF_COUNTER, cpw_pkg::OFF_LIMIT, cpw_pkg::OFF_TCTRL, cpw_pkg::OFF_C1_BUF,
        cpw_pkg::OFF_C1_ACT, cpw_pkg::OFF_C1_CTRL, cpw_pkg::OFF_C2_BUF, cpw_pkg::OFF_C2_ACT,
        cpw_pkg::OFF_C2_CTRL: st_d.rsp.bresp = cpw_pkg::RESP_OKAY;
        default: st_d.rsp.bresp = cpw_pkg::RESP_SLVERR;
      endcase
    end

    // Read path: one read under way, answered the cycle after the address
    if (st_q.rsp.rvalid && axi_req.rready) begin
      st_d.rsp.rvalid = 1'b0;
    end
    if (st_q.rsp.arready && axi_req.arvalid) begin
      st_d.rsp.rvalid = 1'b1;
      st_d.rsp.rresp = cpw_pkg::RESP_OKAY;
      case (axi_req.araddr)
        cpw_pkg::OFF_COUNTER: st_d.rsp.rdata = {24'h000000, st_q.counter};
        cpw_pkg::OFF_LIMIT: st_d.rsp.rdata = {24'h000000, st_q.limit};
        cpw_pkg::OFF_TCTRL: st_d.rsp.rdata = {25'h0000000, st_q.tctrl};
        cpw_pkg::OFF_C1_BUF: st_d.rsp.rdata = {24'h000000, st_q.dbuf[0]};
        cpw_pkg::OFF_C1_ACT: st_d.rsp.rdata = {24'h000000, st_q.dact[0]};
        cpw_pkg::OFF_C1_CTRL: st_d.rsp.rdata = {24'h000000, st_q.cctrl[0]};
        cpw_pkg::OFF_C2_BUF: st_d.rsp.rdata = {24'h000000, st_q.dbuf[1]};
        cpw_pkg::OFF_C2_ACT: st_d.rsp.rdata = {24'h000000, st_q.dact[1]};
        cpw_pkg::OFF_C2_CTRL: st_d.rsp.rdata = {24'h000000, st_q.cctrl[1]};
        default: begin
          st_d.rsp.rdata = 32'h00000000;
          st_d.rsp.rresp = cpw_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Time base: prescaler then period counter
    if (tick) begin
      st_d.presc = 4'h0;
      st_d.counter = roll ? 8'h00 : st_q.counter + 8'h01;
    end else if (timer_run) begin
      st_d.presc = st_q.presc + 4'h1;
    end

    // Output stages
    for (int i = 0; i < 2; i++) begin
      if (chan_off[i]) begin
        st_d.out[i] = 1'b0;
        st_d.dact[i] = 8'h00;
        st_d.dlat[i] = 2'h0;
      end else if (pwm_on[i]) begin
        if (roll) begin
          st_d.dact[i] = st_q.dbuf[i];
          st_d.dlat[i] = st_q.cctrl[i][cpw_pkg::CC_DLO_LSB +: 2];
          st_d.out[i] = (duty_next[i] != 10'h000);
        end else if (match[i]) begin
          st_d.out[i] = 1'b0;
        end
      end else begin
        st_d.out[i] = 1'b0;
      end
    end
    if (st_q.sd_q) begin
      st_d.out[0] = 1'b0;
    end

    // Software writes win over the timer for the same register, except active-duty writes, which are dropped in PWM mode
    if (wr_en) begin
      case (st_q.aw_addr)
        cpw_pkg::OFF_COUNTER: begin
          st_d.counter = st_q.w_data;
          st_d.presc = 4'h0;
        end
        cpw_pkg::OFF_LIMIT: st_d.limit = st_q.w_data;
        cpw_pkg::OFF_TCTRL: st_d.tctrl = st_q.w_data[6:0];
        cpw_pkg::OFF_C1_BUF: st_d.dbuf[0] = st_q.w_data;
        cpw_pkg::OFF_C1_ACT: begin
          if (!pwm_on[0]) begin
            st_d.dact[0] = st_q.w_data;
          end
        end
        cpw_pkg::OFF_C1_CTRL: st_d.cctrl[0] = st_q.w_data;
        cpw_pkg::OFF_C2_BUF: st_d.dbuf[1] = st_q.w_data;
        cpw_pkg::OFF_C2_ACT: begin
          if (!pwm_on[1]) begin
            st_d.dact[1] = st_q.w_data;
          end
        end
        cpw_pkg::OFF_C2_CTRL: st_d.cctrl[1] = st_q.w_data & cpw_pkg::C2_CTRL_MASK;
        default: st_d.limit = st_q.limit;
      endcase
    end

    // Shutdown pin: three stages, a change counts once stages two and three agree
    st_d.sd_meta = shutdown_in;
    st_d.sd_s2 = st_q.sd_meta;
    st_d.sd_s3 = st_q.sd_s2;
    if (st_q.sd_s2 == st_q.sd_s3) begin
      st_d.sd_q = st_q.sd_s3;
    end

    // Ready terms follow from the next occupancy so they stay registered
    st_d.rsp.awready = !st_d.aw_full && !st_d.rsp.bvalid;
    st_d.rsp.wready = !st_d.w_full && !st_d.rsp.bvalid;
    st_d.rsp.arready = !st_d.rsp.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= cpw_pkg::ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign axi_rsp = st_q.rsp;
  assign pwm_output_pin = st_q.out;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_roll2;
    roll && pwm_on[1] && !chan_off[1];
  endsequence

  sequence s_div4_run;
    (ps_sel == cpw_pkg::PS_DIV4) && timer_run && !wr_go;
  endsequence

  property p_clear_on_roll;
    roll && !wr_go |=> st_q.counter == 8'h00;
  endproperty
  a_clear_on_roll: assert property (p_clear_on_roll) else $error("counter not cleared at rollover");

  property p_set_on_roll;
    s_roll2 ##0 (duty_next[1] != 10'h000) |=> st_q.out[1];
  endproperty
  a_set_on_roll: assert property (p_set_on_roll) else $error("pin not set at period start");

  property p_zero_duty;
    s_roll2 ##0 (duty_next[1] == 10'h000) |=> !st_q.out[1] ##1 !st_q.out[1] || roll;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("pin set with zero duty");

  property p_load_duty;
    s_roll2 |=> {st_q.dact[1], st_q.dlat[1]} == $past(duty_next[1]);
  endproperty
  a_load_duty: assert property (p_load_duty) else $error("duty not latched at rollover");

  property p_active_hold;
    pwm_on[1] && !roll |=> $stable(st_q.dact[1]);
  endproperty
  a_active_hold: assert property (p_active_hold) else $error("active duty changed mid period");

  property p_match_clear;
    pwm_on[1] && !roll && match[1] |=> !st_q.out[1];
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("pin not cleared on duty match");

  property p_off_reset;
    chan_off[1] && !wr_go |=> !st_q.out[1] && st_q.dact[1] == 8'h00;
  endproperty
  a_off_reset: assert property (p_off_reset) else $error("off mode did not reset channel");

  property p_div4;
    tick ##0 s_div4_run ##1 s_div4_run [*4] |-> tick;
  endproperty
  a_div4: assert property (p_div4) else $error("divide by four tick spacing wrong");

  property p_stopped;
    !timer_run && !wr_go |=> $stable(st_q.counter);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

  property p_shutdown;
    st_q.sd_q |=> !st_q.out[0];
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("channel one not shut down");

  property p_div1_tick;
    (ps_sel == cpw_pkg::PS_DIV1) && timer_run |-> tick;
  endproperty
  a_div1_tick: assert property (p_div1_tick) else $error("divide by one missed a tick");

  property p_presc_step;
    timer_run && !tick && !wr_go |=> st_q.presc == $past(st_q.presc) + 4'h1;
  endproperty
  a_presc_step: assert property (p_presc_step) else $error("prescaler did not step");

  property p_count_step;
    tick && !roll && !wr_go |=> st_q.counter == $past(st_q.counter) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not advance on tick");

  property p_count_hold;
    timer_run && !tick && !wr_go |=> $stable(st_q.counter);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved between ticks");

  property p_load_duty0;
    roll && pwm_on[0] |=> {st_q.dact[0], st_q.dlat[0]} == $past(duty_next[0]);
  endproperty
  a_load_duty0: assert property (p_load_duty0) else $error("channel one duty not latched");

  property p_active_hold0;
    pwm_on[0] && !roll |=> $stable(st_q.dact[0]);
  endproperty
  a_active_hold0: assert property (p_active_hold0) else $error("channel one active duty changed");

  property p_latch_hold0;
    pwm_on[0] && !roll |=> $stable(st_q.dlat[0]);
  endproperty
  a_latch_hold0: assert property (p_latch_hold0) else $error("low duty bits changed mid period");

  property p_match_clear0;
    pwm_on[0] && !roll && match[0] |=> !st_q.out[0];
  endproperty
  a_match_clear0: assert property (p_match_clear0) else $error("channel one not cleared on match");

  property p_over_period;
    pwm_on[0] && !roll && !st_q.sd_q && st_q.out[0] && (st_q.counter <= st_q.limit) &&
      (st_q.dact[0] > st_q.limit) |=> st_q.out[0];
  endproperty
  a_over_period: assert property (p_over_period) else $error("long duty cleared the pin");

  property p_off_reset0;
    chan_off[0] && !wr_go |=> !st_q.out[0] && st_q.dact[0] == 8'h00 && st_q.dlat[0] == 2'h0;
  endproperty
  a_off_reset0: assert property (p_off_reset0) else $error("channel one off mode not reset");

  property p_ctrl_clear;
    wr_en && (st_q.aw_addr == cpw_pkg::OFF_C2_CTRL) && (st_q.w_data == 8'h00) |-> ##2 !st_q.out[1];
  endproperty
  a_ctrl_clear: assert property (p_ctrl_clear) else $error("cleared control left pin high");

  property p_non_pwm0;
    !pwm_on[0] |=> !st_q.out[0];
  endproperty
  a_non_pwm0: assert property (p_non_pwm0) else $error("channel one driven outside PWM mode");

  property p_non_pwm1;
    !pwm_on[1] |=> !st_q.out[1];
  endproperty
  a_non_pwm1: assert property (p_non_pwm1) else $error("channel two driven outside PWM mode");

endmodule

`default_nettype wire

// *** verif/cpw_load.sv ***
// Load model on one PWM pin: measures high time and period in clock cycles
`timescale 1ns/1ps
`default_nettype none
module cpw_load (
  input wire logic aclk,
  input wire logic pin,
  output logic [15:0] hi_len,
  output logic [15:0] per_len,
  output logic [15:0] rises
);
  logic [15:0] cnt;
  logic [15:0] hcnt;
  logic prev;
  initial begin
    {hi_len, per_len, rises, cnt, hcnt, prev} = '0;
  end
  // Figures refer to the period that just ended, so a changed duty shows one rise late
  always @(posedge aclk) begin
    prev <= pin;
    if (pin && !prev) begin
      hi_len <= hcnt;
      per_len <= cnt;
      rises <= rises + 16'h1;
      cnt <= 16'h1;
      hcnt <= 16'h1;
    end else begin
      cnt <= cnt + 16'h1;
      if (pin) hcnt <= hcnt + 16'h1;
    end
  end
endmodule
`default_nettype wire

// *** verif/cpw_top_tb.sv ***
// Self-checking bench for the two-channel PWM timer
`timescale 1ns/1ps
`default_nettype none
module cpw_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic shutdown_in = 1'b0;
  cpw_pkg::cpw_axi_req_type req = '0;
  cpw_pkg::cpw_axi_rsp_type rsp;
  logic [1:0] pin;
  logic [15:0] hi [2];
  logic [15:0] per [2];
  logic [15:0] rises [2];
  logic [31:0] rd;
  logic [1:0] resp;
  int fails = 0;
  int samples_checked = 0;
  int mdl [int];
  int lim, pf, nb, r0, p16;
  int dty [2];

  always #20 aclk = ~aclk;

  cpw_top cpw_top_inst (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .shutdown_in(shutdown_in), .pwm_output_pin(pin));
  cpw_load load0_inst (.aclk(aclk), .pin(pin[0]), .hi_len(hi[0]), .per_len(per[0]), .rises(rises[0]));
  cpw_load load1_inst (.aclk(aclk), .pin(pin[1]), .hi_len(hi[1]), .per_len(per[1]), .rises(rises[1]));

  // ----
  // Bus and check tasks
  // ----
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Each task lets an edge pass first so no strobe is driven twice in one step
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1 && k < 200);
    req.bready <= 1'b0;
    resp = rsp.bresp;
    if (k >= 200) fails++;
  endtask

  task automatic rdr(input logic [5:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1 && k < 200);
    req.rready <= 1'b0;
    rd = rsp.rdata;
    resp = rsp.rresp;
    if (k >= 200) fails++;
  endtask

  task automatic wm(input logic [5:0] a, input logic [7:0] d);
    wr(a, d);
    chk("bresp", 32'(cpw_pkg::RESP_OKAY), 32'(resp));
    mdl[a] = (a == cpw_pkg::OFF_C2_CTRL) ? (d & 8'h3f) : d;
  endtask

  task automatic rchk(input logic [5:0] a);
    rdr(a);
    chk("rresp", 32'(cpw_pkg::RESP_OKAY), 32'(resp));
    chk($sformatf("reg %h", a), 32'(mdl[a]), rd);
  endtask

  // Three rises so the measured period ran wholly on the new settings
  task automatic tchk(input int ch, input int ehi, input int eper);
    logic [15:0] r;
    r = rises[ch];
    for (int k = 0; k < 5000 && rises[ch] - r < 3; k++) @(posedge aclk);
    chk("high time", 32'(ehi), 32'(hi[ch]));
    chk("period", 32'(eper), 32'(per[ch]));
  endtask

  // ----
  // Tests
  // ----
  initial begin
    void'($urandom(46438));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a <= 32; a += 4) mdl[a] = 0;
    mdl[4] = 8'hff;
    for (int a = 0; a <= 32; a += 4) rchk(6'(a));
    rdr(6'h24);
    chk("rresp", 32'(cpw_pkg::RESP_SLVERR), 32'(resp));
    chk("rdata", 0, rd);
    wr(6'h3c, 8'h5a);
    chk("bresp", 32'(cpw_pkg::RESP_SLVERR), 32'(resp));
    $display("test registers done");
    lim = 3 + $urandom % 8;
    p16 = (lim + 1) * 16;
    foreach (dty[i]) dty[i] = 4 + $urandom % ((lim + 1) * 4 - 4);
    wm(cpw_pkg::OFF_LIMIT, 8'(lim));
    wm(cpw_pkg::OFF_C1_BUF, 8'(dty[0] >> 2));
    wm(cpw_pkg::OFF_C2_BUF, 8'(dty[1] >> 2));
    wm(cpw_pkg::OFF_C1_CTRL, {2'b00, 2'(dty[0]), 4'h0});
    wm(cpw_pkg::OFF_C2_CTRL, {2'b00, 2'(dty[1]), 4'h0});
    for (int p = 0; p < 3; p++) begin
      pf = 1 << (2 * p);
      wm(cpw_pkg::OFF_TCTRL, {1'b0, 4'($urandom), 1'b1, 2'(p)});
      if (p == 0) begin
        wm(cpw_pkg::OFF_C1_CTRL, {2'b00, 2'(dty[0]), 4'hc});
        wm(cpw_pkg::OFF_C2_CTRL, {2'b00, 2'(dty[1]), 4'hc});
      end
      for (int c = 0; c < 2; c++) tchk(c, (pf == 1) ? dty[c] >> 2 : dty[c] * pf / 4, (lim + 1) * pf);
    end
    $display("test prescale done");
    mdl[cpw_pkg::OFF_C1_ACT] = dty[0] >> 2;
    r0 = rises[0];
    for (int k = 0; k < p16 && rises[0] == r0; k++) @(posedge aclk);
    nb = 1 + $urandom % lim;
    wm(cpw_pkg::OFF_C1_BUF, 8'(nb));
    rchk(cpw_pkg::OFF_C1_ACT);
    wr(cpw_pkg::OFF_C1_ACT, 8'h77);
    rchk(cpw_pkg::OFF_C1_ACT);
    dty[0] = nb * 4 + (dty[0] & 3);
    tchk(0, dty[0] * 4, p16);
    mdl[cpw_pkg::OFF_C1_ACT] = nb;
    rchk(cpw_pkg::OFF_C1_ACT);
    $display("test double buffer done");
    wm(cpw_pkg::OFF_C2_BUF, 8'h00);
    wm(cpw_pkg::OFF_C2_CTRL, 8'h0c);
    wm(cpw_pkg::OFF_C1_BUF, 8'hff);
    repeat (p16 + 4) @(posedge aclk);
    nb = rises[0];
    r0 = rises[1];
    repeat (2 * p16) @(posedge aclk);
    chk("ch2 rises", 32'(r0), 32'(rises[1]));
    chk("ch2 pin", 0, 32'(pin[1]));
    chk("ch1 rises", 32'(nb), 32'(rises[0]));
    chk("ch1 pin", 1, 32'(pin[0]));
    $display("test duty limits done");
    shutdown_in <= 1'b1;
    wm(cpw_pkg::OFF_C2_BUF, 8'(dty[1] >> 2));
    wm(cpw_pkg::OFF_C2_CTRL, {2'b00, 2'(dty[1]), 4'hc});
    r0 = rises[1];
    repeat (2 * p16) @(posedge aclk);
    chk("ch1 shut", 0, 32'(pin[0]));
    chk("ch2 live", 1, 32'(rises[1] != r0));
    shutdown_in <= 1'b0;
    wm(cpw_pkg::OFF_C2_CTRL, 8'h00);
    mdl[cpw_pkg::OFF_C2_ACT] = 0;
    repeat (4) @(posedge aclk);
    chk("ch2 off", 0, 32'(pin[1]));
    rchk(cpw_pkg::OFF_C2_ACT);
    repeat (p16) @(posedge aclk);
    chk("ch1 resumed", 1, 32'(pin[0]));
    wm(cpw_pkg::OFF_C1_CTRL, 8'h08);
    repeat (2) @(posedge aclk);
    chk("ch1 non-pwm", 0, 32'(pin[0]));
    rdr(cpw_pkg::OFF_COUNTER);
    chk("count range", 1, 32'(rd <= lim));
    wm(cpw_pkg::OFF_TCTRL, 8'h02);
    rdr(cpw_pkg::OFF_COUNTER);
    r0 = rd;
    repeat (20) @(posedge aclk);
    rdr(cpw_pkg::OFF_COUNTER);
    chk("held count", 32'(r0), rd);
    $display("test shutdown and off done");
    test_done;
  end

  // Longest run is a few thousand cycles; this limit leaves a wide margin
  initial begin
    repeat (60000) @(posedge aclk);
    fails++;
    test_done;
  end
endmodule
`default_nettype wire
